// ### inc/sse_consts.svh
`ifndef SSE_CONSTS_SVH
`define SSE_CONSTS_SVH

// Opcode encodings of the execute port
`define SSE_OP_NONE      2'h0
`define SSE_OP_SUB       2'h1
`define SSE_OP_SUBB      2'h2
`define SSE_OP_SLEEP     2'h3

// Reset values
`define SSE_W_RST        8'h00
`define SSE_WATCHDOG_RST 8'h00
`define SSE_PRE_RST      8'h00
`define SSE_ZERO_BYTE    8'h00
`define SSE_PWRDN_N_RST  1'h1
`define SSE_TMO_N_RST    1'h1

// Destination select values
`define SSE_DEST_W       1'h0
`define SSE_DEST_F       1'h1

// Nibble boundary for digit carry and byte boundary for the result
`define SSE_NIB_HI       3
`define SSE_BYTE_HI      7

`endif

// ### inc/sse_pkg.sv
package sse_pkg;

  typedef enum logic [1:0] {
    SSE_OP_NONE_E  = 2'h0,
    SSE_OP_SUB_E   = 2'h1,
    SSE_OP_SUBB_E  = 2'h2,
    SSE_OP_SLEEP_E = 2'h3
  } sse_op_e;

  typedef enum logic [1:0] {
    SSE_RUN   = 2'h1,
    SSE_ASLEEP = 2'h2
  } sse_state_e;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } sse_flags_s;

  typedef struct packed {
    logic [7:0] diff;
    sse_flags_s flags;
  } sse_sub_s;

endpackage

// ### hdl/sse_subtractor.sv
`timescale 1ns/1ps
`default_nettype none
`include "sse_consts.svh"

module sse_subtractor #(
  parameter int WIDTH = 8
) (
  input  wire logic          borrow_en,
  input  wire logic          carry_in,
  input  wire logic [7:0]    file_val,
  input  wire logic [7:0]    w_val,
  output var sse_pkg::sse_sub_s result
);

  // Flag logic is written for byte operands only
  if (WIDTH != 8)
  begin
    $error("sse_subtractor supports WIDTH of 8 only");
  end

  logic [8:0] full;
  logic [4:0] low;
  logic       bin;

  always_comb
  begin
    bin  = borrow_en & ~carry_in;
    full = {1'b0, file_val} + {1'b0, ~w_val} + 9'h001 - {8'h00, bin};
    low  = {1'b0, file_val[`SSE_NIB_HI:0]} + {1'b0, ~w_val[`SSE_NIB_HI:0]} + 5'h01 - {4'h0, bin};
    result.diff                   = full[`SSE_BYTE_HI:0];
    result.flags.carry            = full[8];
    result.flags.digit_carry_flag = low[4];
    result.flags.zero             = (full[`SSE_BYTE_HI:0] == `SSE_ZERO_BYTE);
  end

endmodule
`default_nettype wire

// ### hdl/sse_exec.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sse_consts.svh"

module sse_exec #(
  parameter int PRE_WIDTH = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire sse_pkg::sse_op_e  op,
  input  wire logic              op_valid,
  input  wire logic              dest_sel,
  input  wire logic [7:0]        file_val,
  input  wire logic              watchdog_tick,
  input  wire logic              wake,
  output logic [7:0]             w_reg_out,
  output logic [7:0]             file_wr_data,
  output logic                   file_wr_en,
  output logic                   carry,
  output logic                   digit_carry_flag,
  output logic                   zero,
  output logic                   power_down_flag_n,
  output logic                   timeout_flag_n,
  output logic [7:0]             watchdog_counter,
  output logic                   osc_run,
  output logic                   asleep
);

  // Refused at elaboration, not at run time
  if (PRE_WIDTH < 1 || PRE_WIDTH > 16)
  begin
    $error("PRE_WIDTH out of range");
  end

  typedef struct packed {
    sse_pkg::sse_state_e  state;
    logic [7:0]           w;
    logic [7:0]           fdata;
    logic                 fwe;
    sse_pkg::sse_flags_s  flags;
    logic                 pwrdn_n;
    logic                 tmo_n;
    logic [7:0]           wdog;
    logic [PRE_WIDTH-1:0] pre;
  } sse_st_s;

  sse_st_s           st_reg;
  sse_st_s           st_next;
  sse_pkg::sse_sub_s sub;
  logic              running;

  assign running = (st_reg.state == sse_pkg::SSE_RUN);

  sse_subtractor #(
    .WIDTH (8)
  ) i_sse_subtractor (
    .borrow_en (op == sse_pkg::SSE_OP_SUBB_E),
    .carry_in  (st_reg.flags.carry),
    .file_val  (file_val),
    .w_val     (st_reg.w),
    .result    (sub)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_next     = st_reg;
    st_next.fwe = 1'b0;
    case (st_reg.state)
      sse_pkg::SSE_RUN:
      begin
        // Watchdog keeps counting while awake
        if (watchdog_tick)
        begin
          st_next.pre = st_reg.pre + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
          if (&st_reg.pre)
            st_next.wdog = st_reg.wdog + 8'h01;
        end
        if (op_valid)
        begin
          case (op)
            sse_pkg::SSE_OP_SUB_E, sse_pkg::SSE_OP_SUBB_E:
            begin
              st_next.flags = sub.flags;
              if (dest_sel == `SSE_DEST_W)
                st_next.w = sub.diff;
              else
              begin
                st_next.fdata = sub.diff;
                st_next.fwe   = 1'b1;
              end
            end
            sse_pkg::SSE_OP_SLEEP_E:
            begin
              st_next.wdog    = `SSE_WATCHDOG_RST;
              st_next.pre     = '0;
              st_next.pwrdn_n = 1'b0;
              st_next.tmo_n   = 1'b1;
              st_next.state = sse_pkg::SSE_ASLEEP;
            end
            default:
            begin
              st_next.fwe = 1'b0;
            end
          endcase
        end
      end
      sse_pkg::SSE_ASLEEP:
      begin
        // Instructions ignored until wake
        if (wake)
          st_next.state = sse_pkg::SSE_RUN;
      end
      default:
      begin
        st_next.state = sse_pkg::SSE_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg.state <= sse_pkg::SSE_RUN;
      st_reg.w     <= `SSE_W_RST;
      st_reg.fdata <= `SSE_ZERO_BYTE;
      st_reg.fwe   <= 1'b0;
      st_reg.flags <= '0;
      st_reg.pwrdn_n <= `SSE_PWRDN_N_RST;
      st_reg.tmo_n   <= `SSE_TMO_N_RST;
      st_reg.wdog    <= `SSE_WATCHDOG_RST;
      st_reg.pre   <= '0;
    end
    else
      st_reg <= st_next;
  end

  assign w_reg_out         = st_reg.w;
  assign file_wr_data      = st_reg.fdata;
  assign file_wr_en        = st_reg.fwe;
  assign carry             = st_reg.flags.carry;
  assign digit_carry_flag  = st_reg.flags.digit_carry_flag;
  assign zero              = st_reg.flags.zero;
  assign power_down_flag_n = st_reg.pwrdn_n;
  assign timeout_flag_n    = st_reg.tmo_n;
  assign watchdog_counter  = st_reg.wdog;
  // One-hot state bits drive the pins with no decode
  assign osc_run           = st_reg.state[0];
  assign asleep            = st_reg.state[1];

  ////////////////////////////////////////////////////////////////////////////
  // watchdog cleared on sleep
  property p_watchdog_clear;
    @(posedge sys_clk) disable iff (rst)
      (running && op_valid && op == sse_pkg::SSE_OP_SLEEP_E) |=> (watchdog_counter == 8'h00 && st_reg.pre == '0);
  endproperty
  a_watchdog_clear: assert property (p_watchdog_clear) else $error("watchdog not cleared by sleep");

  property p_flags_sleep;
    @(posedge sys_clk) disable iff (rst)
      (running && op_valid && op == sse_pkg::SSE_OP_SLEEP_E)
        |=> (!power_down_flag_n && timeout_flag_n && carry == $past(carry) && zero == $past(zero)
             && digit_carry_flag == $past(digit_carry_flag));
  endproperty
  a_flags_sleep: assert property (p_flags_sleep) else $error("sleep status flags wrong");

  property p_halt;
    @(posedge sys_clk) disable iff (rst)
      (asleep && !wake) |=> (asleep && !osc_run && !file_wr_en && $stable(w_reg_out));
  endproperty
  a_halt: assert property (p_halt) else $error("execution during sleep");

  property p_sub_val;
    @(posedge sys_clk) disable iff (rst)
      (running && op_valid && op == sse_pkg::SSE_OP_SUB_E && dest_sel == 1'b0)
        |=> (w_reg_out == 8'($past(file_val) - $past(w_reg_out)));
  endproperty
  a_sub_val: assert property (p_sub_val) else $error("subtract result wrong");

  property p_sub_dest;
    @(posedge sys_clk) disable iff (rst)
      (running && op_valid && op == sse_pkg::SSE_OP_SUB_E && dest_sel)
        |=> (file_wr_en && file_wr_data == 8'($past(file_val) - $past(w_reg_out)) && $stable(w_reg_out));
  endproperty
  a_sub_dest: assert property (p_sub_dest) else $error("subtract destination wrong");

  property p_subb_val;
    @(posedge sys_clk) disable iff (rst)
      (running && op_valid && op == sse_pkg::SSE_OP_SUBB_E && dest_sel == 1'b0)
        |=> (w_reg_out == 8'($past(file_val) - $past(w_reg_out) - {7'h00, ~$past(carry)}));
  endproperty
  a_subb_val: assert property (p_subb_val) else $error("borrow subtract wrong");

  property p_subb_dest;
    @(posedge sys_clk) disable iff (rst)
      (running && op_valid && op == sse_pkg::SSE_OP_SUBB_E && dest_sel)
        |=> (file_wr_en && $stable(w_reg_out)
             && file_wr_data == 8'($past(file_val) - $past(w_reg_out) - {7'h00, ~$past(carry)}));
  endproperty
  a_subb_dest: assert property (p_subb_dest) else $error("borrow subtract destination wrong");

  property p_sub_flags;
    @(posedge sys_clk) disable iff (rst)
      (running && op_valid && op == sse_pkg::SSE_OP_SUB_E)
        |=> (carry == ($past(w_reg_out) <= $past(file_val))
             && digit_carry_flag == ($past(w_reg_out[3:0]) <= $past(file_val[3:0]))
             && zero == ($past(file_val) == $past(w_reg_out)));
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

endmodule
`default_nettype wire

// ### testbench/sse_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module sse_exec_test;
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  sse_pkg::sse_op_e op = sse_pkg::SSE_OP_NONE_E;
  logic             op_valid = 1'b0;
  logic             dest_sel = 1'b0;
  logic [7:0]       file_val = 8'h00;
  logic             watchdog_tick = 1'b0;
  logic             wake = 1'b0;
  logic [7:0]       w_reg_out;
  logic [7:0]       file_wr_data;
  logic             file_wr_en;
  logic             carry;
  logic             digit_carry_flag;
  logic             zero;
  logic             power_down_flag_n;
  logic             timeout_flag_n;
  logic [7:0]       watchdog_counter;
  logic             osc_run;
  logic             asleep;
  int               miscompares = 0;
  int               num_checks = 0;
  logic [7:0]       w_m = 8'h00;
  logic             c_m = 1'b0;

  always #2.5 sys_clk = ~sys_clk;

  // Short prescaler keeps the tick sequences brief
  sse_exec #(.PRE_WIDTH(2)) i_sse_exec (
    .sys_clk(sys_clk), .rst(rst), .op(op), .op_valid(op_valid), .dest_sel(dest_sel),
    .file_val(file_val), .watchdog_tick(watchdog_tick), .wake(wake), .w_reg_out(w_reg_out),
    .file_wr_data(file_wr_data), .file_wr_en(file_wr_en), .carry(carry),
    .digit_carry_flag(digit_carry_flag), .zero(zero), .power_down_flag_n(power_down_flag_n),
    .timeout_flag_n(timeout_flag_n), .watchdog_counter(watchdog_counter), .osc_run(osc_run),
    .asleep(asleep)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp1(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out;
    $display("Checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One instruction, started and ended at a rising edge
  task automatic run_op(input sse_pkg::sse_op_e o, input logic d, input logic [7:0] f);
    logic [8:0] full;
    logic [4:0] nib;
    logic       b;
    b = (o == sse_pkg::SSE_OP_SUBB_E) ? ~c_m : 1'b0;
    full = {1'b0, f} - {1'b0, w_m} - {8'h00, b};
    nib = {1'b0, f[3:0]} - {1'b0, w_m[3:0]} - {4'h0, b};
    op <= o;
    dest_sel <= d;
    file_val <= f;
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    c_m = ~full[8];
    if (d == 1'b0)
      w_m = full[7:0];
    cmp8("w_reg_out", w_m, w_reg_out);
    cmp1("file_wr_en", d, file_wr_en);
    if (d)
      cmp8("file_wr_data", full[7:0], file_wr_data);
    cmp1("carry", c_m, carry);
    cmp1("digit_carry_flag", ~nib[4], digit_carry_flag);
    cmp1("zero", full[7:0] == 8'h00, zero);
    @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    cmp1("power_down_flag_n", 1'b1, power_down_flag_n);
    cmp1("osc_run", 1'b1, osc_run);
    @(posedge sys_clk);
    // Fourteen ticks leave the prescaler part way
    watchdog_tick <= 1'b1;
    repeat (14) @(posedge sys_clk);
    watchdog_tick <= 1'b0;
    #1;
    cmp8("watchdog_counter", 8'h03, watchdog_counter);
    @(posedge sys_clk);
    run_op(sse_pkg::SSE_OP_SUB_E, 1'b0, 8'h05);
    run_op(sse_pkg::SSE_OP_SUB_E, 1'b1, 8'h03);
    run_op(sse_pkg::SSE_OP_SUBB_E, 1'b1, 8'h05);
    run_op(sse_pkg::SSE_OP_SUBB_E, 1'b0, 8'h15);
    run_op(sse_pkg::SSE_OP_SUBB_E, 1'b0, 8'h0f);
    // Power-down clears the counter and halts
    op <= sse_pkg::SSE_OP_SLEEP_E;
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    cmp8("watchdog_counter", 8'h00, watchdog_counter);
    cmp1("power_down_flag_n", 1'b0, power_down_flag_n);
    cmp1("timeout_flag_n", 1'b1, timeout_flag_n);
    cmp1("carry", c_m, carry);
    cmp1("asleep", 1'b1, asleep);
    cmp1("osc_run", 1'b0, osc_run);
    @(posedge sys_clk);
    // Instructions while asleep must not execute
    op <= sse_pkg::SSE_OP_SUB_E;
    file_val <= 8'h77;
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    cmp8("w_reg_out", w_m, w_reg_out);
    cmp1("file_wr_en", 1'b0, file_wr_en);
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    #1;
    cmp1("asleep", 1'b0, asleep);
    cmp1("power_down_flag_n", 1'b0, power_down_flag_n);
    @(posedge sys_clk);
    // Three ticks only: a stale prescaler would wrap here
    watchdog_tick <= 1'b1;
    repeat (3) @(posedge sys_clk);
    watchdog_tick <= 1'b0;
    #1;
    cmp8("watchdog_counter", 8'h00, watchdog_counter);
    @(posedge sys_clk);
    run_op(sse_pkg::SSE_OP_SUB_E, 1'b1, w_m);
    // Idle opcode with the strobe high changes nothing
    op <= sse_pkg::SSE_OP_NONE_E;
    file_val <= 8'h42;
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    cmp8("w_reg_out", w_m, w_reg_out);
    cmp1("file_wr_en", 1'b0, file_wr_en);
    cmp1("carry", c_m, carry);
    cmp1("zero", 1'b1, zero);
    @(posedge sys_clk);
    close_out();
  end

  initial
  begin
    #(5 * 400);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
